/* core/pcfg_cmd_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface pcfg_cmd_if;
  logic        wr_en;
  logic [1:0]  wr_be;
  logic [15:0] wr_data;
  logic [15:0] value;

  modport ctrl
  (
    output wr_en,
    output wr_be,
    output wr_data,
    input  value
  );

  modport store
  (
    input  wr_en,
    input  wr_be,
    input  wr_data,
    output value
  );
endinterface

`default_nettype wire

/* core/pcfg_cmd_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module pcfg_cmd_reg
  import pcfg_pkg::*;
(
  input wire logic  clk,
  input wire logic  rst_sync_n,
  pcfg_cmd_if.store cmd
);

  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_bit
      if (PCFG_CMD_WR_MASK[i])
      begin : g_rw
        logic bit_q;
        logic next_bit_q;

        always_comb
        begin
          next_bit_q = bit_q;
          if (cmd.wr_en && cmd.wr_be[i / 8])
          begin
            next_bit_q = cmd.wr_data[i];
          end
        end

        always_ff @(posedge clk or negedge rst_sync_n)
        begin
          if (!rst_sync_n)
          begin
            bit_q <= PCFG_CMD_RESET[i];
          end
          else
          begin
            bit_q <= next_bit_q;
          end
        end

        assign cmd.value[i] = bit_q;
      end
      else
      begin : g_ro
        // Hardwired: writes land nowhere
        assign cmd.value[i] = 1'b0;
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* core/pcfg_id_cmd.sv */
// Function
// - Vendor code at offset 00h, writes ignored
// - Device code at offset 02h, read-only
// - Command register at 04h, resets to 0000h
// - Command bits 15..10 read zero
// - No fast back-to-back; bit 9 zero
// - Bit 8 enables system-error output driver
// - Address parity error drives SERR when 8,6 set
// - No address/data stepping; bit 7 zero
// - Bit 6 enables parity error response
// - Bit 5 snoops palette writes, no claim
// - No write-and-invalidate; use memory write
// - No special cycles; bit 3 zero
// - Initiator requests only while bit 2 set
// - Memory cycles claimed only while bit 1
// - I/O cycles claimed only while bit 0
`timescale 1ns/1ps
`default_nettype none

module pcfg_id_cmd
  import pcfg_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h5678  // Arbitrary value
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic      [31:0] cfg_rdata,
  input  wire logic [15:0] status_word,
  input  wire logic        tgt_mem_hit,
  input  wire logic        tgt_io_hit,
  input  wire logic        tgt_palette_wr,
  input  wire logic        tgt_special_hit,
  input  wire logic [31:0] tgt_wdata,
  output logic             mem_claim,
  output logic             io_claim,
  output logic             palette_snoop,
  output logic      [31:0] palette_data,
  input  wire logic        init_req,
  input  wire logic [3:0]  init_cmd,
  output logic             bus_request,
  output logic      [3:0]  bus_cmd,
  input  wire logic        addr_par_err,
  input  wire logic        data_par_err,
  output logic             serr_o,
  output logic             serr_oe_n,
  output logic             perr_o,
  output logic             perr_oe_n,
  output logic             system_error_driver_enable,
  output logic             parity_response_enable,
  output logic             bus_initiator_enable,
  output logic             back_to_back_enable,
  output logic             write_invalidate_enable
);

  // Reset release synchroniser
  logic        rst_meta;
  logic        rst_sync_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Command register storage
  pcfg_cmd_if cmd_bus ();

  pcfg_cmd_reg u_cmd
  (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .cmd        (cmd_bus.store)
  );

  logic [15:0] cmd_val;
  assign cmd_val = cmd_bus.value;

  // Configuration access sequencer
  pcfg_state_t state;
  pcfg_state_t next_state;
  logic [31:0] rdata_q;
  logic [31:0] next_rdata_q;
  logic        take;
  logic        hit_id;
  logic        hit_cmd;

  assign take    = (state == PCFG_ST_IDLE) && cfg_req;
  assign hit_id  = (cfg_addr == PCFG_OFS_ID);
  assign hit_cmd = (cfg_addr == PCFG_OFS_CMD);

  always_comb
  begin
    next_state   = state;
    next_rdata_q = rdata_q;
    case (state)
      PCFG_ST_IDLE:
      begin
        if (cfg_req)
        begin
          next_state   = PCFG_ST_RESP;
          next_rdata_q = 32'h0000_0000;
          if (!cfg_we && hit_id)
          begin
            next_rdata_q = {DEVICE_CODE, VENDOR_CODE};
          end
          else if (!cfg_we && hit_cmd)
          begin
            next_rdata_q = {status_word, cmd_val};
          end
        end
      end
      PCFG_ST_RESP:
      begin
        next_state = PCFG_ST_IDLE;
      end
      default:
      begin
        next_state = PCFG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state   <= PCFG_ST_IDLE;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      state   <= next_state;
      rdata_q <= next_rdata_q;
    end
  end

  assign cfg_ack   = (state == PCFG_ST_RESP);
  assign cfg_rdata = rdata_q;

  // Only the command half of dword 04h is writable here; ID writes vanish
  assign cmd_bus.wr_en   = take && cfg_we && hit_cmd;
  assign cmd_bus.wr_be   = cfg_be[1:0];
  assign cmd_bus.wr_data = cfg_wdata[15:0];

  // Target claim gating
  logic        snoop_now;

  assign snoop_now = tgt_palette_wr && cmd_val[PCFG_BIT_PALETTE];

  // Combinational so the claim meets the decode window
  always_comb
  begin
    mem_claim = tgt_mem_hit && cmd_val[PCFG_BIT_MEM] && !snoop_now;
    io_claim  = tgt_io_hit && cmd_val[PCFG_BIT_IO] && !snoop_now;
    if (tgt_special_hit)
    begin
      mem_claim = 1'b0;
      io_claim  = 1'b0;
    end
  end

  // Palette snoop capture
  logic        snoop_q;
  logic        next_snoop_q;
  logic [31:0] snoop_data_q;
  logic [31:0] next_snoop_data_q;

  always_comb
  begin
    next_snoop_q      = snoop_now;
    next_snoop_data_q = snoop_data_q;
    if (snoop_now)
    begin
      next_snoop_data_q = tgt_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      snoop_q      <= 1'b0;
      snoop_data_q <= 32'h0000_0000;
    end
    else
    begin
      snoop_q      <= next_snoop_q;
      snoop_data_q <= next_snoop_data_q;
    end
  end

  assign palette_snoop = snoop_q;
  assign palette_data  = snoop_data_q;

  // Initiator path
  logic        req_q;
  logic        next_req_q;
  logic [3:0]  bcmd_q;
  logic [3:0]  next_bcmd_q;

  always_comb
  begin
    // Clearing the enable drops a pending request at the next clock edge
    next_req_q  = init_req && cmd_val[PCFG_BIT_INIT];
    next_bcmd_q = bcmd_q;
    if (init_req)
    begin
      next_bcmd_q = init_cmd;
      if (init_cmd == PCFG_BUSCMD_MWI)
      begin
        next_bcmd_q = PCFG_BUSCMD_MEM_WR;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      req_q  <= 1'b0;
      bcmd_q <= 4'h0;
    end
    else
    begin
      req_q  <= next_req_q;
      bcmd_q <= next_bcmd_q;
    end
  end

  assign bus_request = req_q;
  assign bus_cmd     = bcmd_q;

  // Parity error signalling
  logic        serr_q;
  logic        next_serr_q;
  logic        perr_q;
  logic        next_perr_q;
  logic        perr_rel_q;
  logic        next_perr_rel_q;

  always_comb
  begin
    next_serr_q = addr_par_err
                && cmd_val[PCFG_BIT_SERR]
                && cmd_val[PCFG_BIT_PARITY];
    next_perr_q = data_par_err && cmd_val[PCFG_BIT_PARITY];
    // PERR is driven high one cycle before release
    next_perr_rel_q = perr_q && !next_perr_q;
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      serr_q     <= 1'b0;
      perr_q     <= 1'b0;
      perr_rel_q <= 1'b0;
    end
    else
    begin
      serr_q     <= next_serr_q;
      perr_q     <= next_perr_q;
      perr_rel_q <= next_perr_rel_q;
    end
  end

  // SERR is open drain and only ever pulls low; PERR is driven high for one cycle before release
  assign serr_o    = 1'b0;
  assign serr_oe_n = !serr_q;
  assign perr_o    = !perr_q;
  assign perr_oe_n = !(perr_q || perr_rel_q);

  // Enable views for the rest of the interface
  assign system_error_driver_enable = cmd_val[PCFG_BIT_SERR];
  assign parity_response_enable     = cmd_val[PCFG_BIT_PARITY];
  assign bus_initiator_enable       = cmd_val[PCFG_BIT_INIT];
  assign back_to_back_enable        = cmd_val[PCFG_BIT_B2B];
  assign write_invalidate_enable    = cmd_val[PCFG_BIT_MWI];

endmodule

`default_nettype wire

/* core/pcfg_pkg.sv */
package pcfg_pkg;

  localparam logic [7:0]  PCFG_OFS_ID       = 8'h00;
  localparam logic [7:0]  PCFG_OFS_CMD      = 8'h04;
  localparam logic [7:0]  PCFG_OFS_VENDOR   = 8'h00;
  localparam logic [7:0]  PCFG_OFS_DEVICE   = 8'h02;

  localparam int          PCFG_BIT_IO       = 0;
  localparam int          PCFG_BIT_MEM      = 1;
  localparam int          PCFG_BIT_INIT     = 2;
  localparam int          PCFG_BIT_SPECIAL  = 3;
  localparam int          PCFG_BIT_MWI      = 4;
  localparam int          PCFG_BIT_PALETTE  = 5;
  localparam int          PCFG_BIT_PARITY   = 6;
  localparam int          PCFG_BIT_STEP     = 7;
  localparam int          PCFG_BIT_SERR     = 8;
  localparam int          PCFG_BIT_B2B      = 9;

  localparam logic [15:0] PCFG_CMD_RESET    = 16'h0000;
  localparam logic [15:0] PCFG_CMD_WR_MASK  = 16'h0167;

  localparam logic [3:0]  PCFG_BUSCMD_MEM_WR = 4'h7;
  localparam logic [3:0]  PCFG_BUSCMD_MWI    = 4'hf;

  typedef enum logic [1:0]
  {
    PCFG_ST_IDLE = 2'b01,
    PCFG_ST_RESP = 2'b10
  } pcfg_state_t;

endpackage

/* testbench/pcfg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module pcfg_host
(
  input  wire logic        clk,
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata,
  output logic             cfg_req,
  output logic             cfg_we,
  output logic      [7:0]  cfg_addr,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata
);
  logic [3:0] be_sel = 4'h3;
  int         timeouts = 0;
  initial
  begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 8'hff;
    cfg_be = 4'h3;
    cfg_wdata = 32'h0;
  end
  // Byte enables for all later accesses until set again; held for the whole request
  task automatic set_be(input logic [3:0] b);
    be_sel = b;
  endtask
  // Held until ack is seen or 8 clocks pass; released address and data show inverse, not stale data
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_addr = a;
    cfg_be = be_sel;
    cfg_wdata = wd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (cfg_ack !== 1'b1 && n < 8);
    // A missing answer counts against the run
    if (cfg_ack !== 1'b1)
      timeouts++;
    rd = cfg_rdata;
    #1;
    cfg_req = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~wd;
  endtask
endmodule
`default_nettype wire

/* testbench/pcfg_id_cmd_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pcfg_id_cmd_assertions
  import pcfg_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       cfg_req,
  input wire logic       cfg_ack,
  input wire logic       tgt_mem_hit,
  input wire logic       tgt_special_hit,
  input wire logic       tgt_palette_wr,
  input wire logic       mem_claim,
  input wire logic       palette_snoop,
  input wire logic       init_req,
  input wire logic       bus_request,
  input wire logic [3:0] bus_cmd,
  input wire logic       addr_par_err,
  input wire logic       data_par_err,
  input wire logic       serr_oe_n,
  input wire logic       perr_o,
  input wire logic       perr_oe_n,
  input wire logic       system_error_driver_enable,
  input wire logic       parity_response_enable,
  input wire logic       bus_initiator_enable,
  input wire logic       back_to_back_enable,
  input wire logic       write_invalidate_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack_answer;
    cfg_req && !cfg_ack |=> cfg_ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("access not answered");
  property p_ack_pulse;
    cfg_ack |=> !cfg_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_mem_claim;
    mem_claim |-> tgt_mem_hit && !tgt_special_hit;
  endproperty
  a_mem_claim: assert property (p_mem_claim) else $error("bad memory claim");
  property p_snoop;
    palette_snoop |-> $past(tgt_palette_wr);
  endproperty
  a_snoop: assert property (p_snoop) else $error("snoop without palette write");
  property p_bus_req;
    init_req && bus_initiator_enable |=> bus_request;
  endproperty
  a_bus_req: assert property (p_bus_req) else $error("request not raised");
  property p_serr;
    addr_par_err && system_error_driver_enable && parity_response_enable |=> !serr_oe_n;
  endproperty
  a_serr: assert property (p_serr) else $error("system error not driven");
  property p_perr;
    data_par_err && parity_response_enable |=> !perr_oe_n && !perr_o;
  endproperty
  a_perr: assert property (p_perr) else $error("parity error not driven");
  property p_fixed;
    !back_to_back_enable && !write_invalidate_enable && bus_cmd != 4'hf;
  endproperty
  a_fixed: assert property (p_fixed) else $error("hardwired feature seen");
endmodule
`default_nettype wire

/* testbench/pcfg_id_cmd_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pcfg_id_cmd_tb;
  localparam logic [15:0] VC = 16'h2468; // Arbitrary value
  localparam logic [15:0] DC = 16'h1357; // Arbitrary value
  localparam logic [15:0] ST = 16'ha5c3;
  logic clk, rst_n, cfg_req, cfg_we, cfg_ack, mem_claim, io_claim, palette_snoop;
  logic tgt_mem_hit, tgt_io_hit, tgt_palette_wr, tgt_special_hit, init_req, bus_request;
  logic addr_par_err, data_par_err, serr_o, serr_oe_n, perr_o, perr_oe_n;
  logic system_error_driver_enable, parity_response_enable, bus_initiator_enable;
  logic back_to_back_enable, write_invalidate_enable;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be, init_cmd, bus_cmd;
  logic [15:0] status_word, e;
  logic [31:0] cfg_wdata, cfg_rdata, tgt_wdata, palette_data, d;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  pcfg_id_cmd #(.VENDOR_CODE(VC), .DEVICE_CODE(DC)) DUT (.clk, .rst_n, .cfg_req, .cfg_we, .cfg_addr,
    .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata, .status_word, .tgt_mem_hit, .tgt_io_hit, .tgt_palette_wr,
    .tgt_special_hit, .tgt_wdata, .mem_claim, .io_claim, .palette_snoop, .palette_data, .init_req, .init_cmd,
    .bus_request, .bus_cmd, .addr_par_err, .data_par_err, .serr_o, .serr_oe_n, .perr_o, .perr_oe_n,
    .system_error_driver_enable, .parity_response_enable, .bus_initiator_enable, .back_to_back_enable,
    .write_invalidate_enable);
  pcfg_host host (.clk, .cfg_ack, .cfg_rdata, .cfg_req, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata);
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task finish_test;
    errors = errors + host.timeouts;
    $display("errors %0d of %0d checks", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      finish_test();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, s, x);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0, d);
    chk(d, x);
  endtask
  // One command value drives every enable-gated path in turn
  task run(input logic [15:0] c);
    e = c & 16'h0167;
    host.xfer(1'b1, 8'h04, {16'hffff, c}, d);
    rd(8'h04, {ST, e});
    chk({27'h0, system_error_driver_enable, parity_response_enable, bus_initiator_enable, back_to_back_enable,
      write_invalidate_enable}, {27'h0, e[8], e[6], e[2], 2'b00});
    tgt_mem_hit = 1'b1;
    tgt_io_hit = 1'b1;
    #1 chk({30'h0, mem_claim, io_claim}, {30'h0, e[1:0]});
    tgt_special_hit = 1'b1;
    #1 chk({30'h0, mem_claim, io_claim}, 32'h0);
    tgt_special_hit = 1'b0;
    tgt_palette_wr = 1'b1;
    tgt_wdata = {c, ~c};
    init_req = 1'b1;
    init_cmd = 4'hf;
    addr_par_err = 1'b1;
    data_par_err = 1'b1;
    #1 chk({30'h0, mem_claim, io_claim}, {30'h0, e[1:0] & {2{~e[5]}}});
    @(posedge clk);
    #1;
    {tgt_palette_wr, init_req, addr_par_err, data_par_err, tgt_mem_hit, tgt_io_hit} = 6'h0;
    chk({31'h0, palette_snoop}, {31'h0, e[5]});
    if (e[5]) chk(palette_data, {c, ~c});
    chk({31'h0, bus_request}, {31'h0, e[2]});
    if (e[2]) chk({28'h0, bus_cmd}, 32'h7);
    chk({30'h0, serr_oe_n, serr_o}, {30'h0, ~(e[8] & e[6]), 1'b0});
    chk({30'h0, perr_oe_n, perr_o}, {30'h0, {2{~e[6]}}});
    // One cycle on: pulses gone, PERR in its driven-high release cycle
    @(posedge clk);
    #1;
    chk({29'h0, palette_snoop, bus_request, serr_oe_n}, 32'h1);
    chk({30'h0, perr_oe_n, perr_o}, {30'h0, ~e[6], 1'b1});
    if (e[5]) chk(palette_data, {c, ~c});
  endtask
  initial
  begin
    {rst_n, tgt_mem_hit, tgt_io_hit, tgt_palette_wr, tgt_special_hit, init_req, addr_par_err, data_par_err} = 8'h0;
    init_cmd = 4'h0;
    tgt_wdata = 32'h0;
    status_word = ST;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h00, {DC, VC});
    rd(8'h04, {ST, 16'h0000});
    host.xfer(1'b1, 8'h00, 32'hffffffff, d);
    host.xfer(1'b1, 8'h08, 32'hffffffff, d);
    rd(8'h00, {DC, VC});
    rd(8'h08, 32'h0);
    rd(8'h04, {ST, 16'h0000});
    run(16'hffff);
    run(16'h0000);
    run(16'hfe98);
    run(16'h0047);
    run(16'h0026);
    // Byte lanes: each enable writes only its own command byte
    host.set_be(4'h2);
    host.xfer(1'b1, 8'h04, 32'h0000ffff, d);
    rd(8'h04, {ST, 16'h0126});
    host.set_be(4'h1);
    host.xfer(1'b1, 8'h04, 32'h0, d);
    rd(8'h04, {ST, 16'h0100});
    host.set_be(4'hc);
    host.xfer(1'b1, 8'h04, 32'hffffffff, d);
    rd(8'h04, {ST, 16'h0100});
    host.set_be(4'h3);
    // Reset in mid-run must clear a nonzero command
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h04, {ST, 16'h0000});
    chk({29'h0, system_error_driver_enable, parity_response_enable, bus_initiator_enable}, 32'h0);
    finish_test();
  end
endmodule
bind pcfg_id_cmd pcfg_id_cmd_assertions u_chk (.clk, .rst_n, .cfg_req, .cfg_ack, .tgt_mem_hit, .tgt_special_hit,
  .tgt_palette_wr, .mem_claim, .palette_snoop, .init_req, .bus_request, .bus_cmd, .addr_par_err, .data_par_err,
  .serr_oe_n, .perr_o, .perr_oe_n, .system_error_driver_enable, .parity_response_enable, .bus_initiator_enable,
  .back_to_back_enable, .write_invalidate_enable);
`default_nettype wire
